// [core/cmr_top.sv]
// colour matrix with chroma scaling, offset and ranging, AXI4-Lite regs
//
// Function
// - each coefficient is 12-bit two's complement, 3.9 format, 200h unity
// - half-scale bit clear: 8-bit chroma full range means plus/minus one
// - half-scale bit set: 8-bit chroma full range means plus/minus half
// - skip clear, luma/chroma input: subtract 128 from chroma first
// - offset chroma outputs: add 128, then apply range limiting
// - range choice set: luma and chroma outputs limited to 1..254
// - range choice clear: luma 16..235, chroma 16..240
// - values beyond a limit are replaced by that limit
// - luma/chroma to RGB: same range choice limits incoming samples
// - colour-difference data without offset is signed 8-bit -128..127
// - RGB and luma data are unsigned 8-bit 0..255
// - range choice is control bit 1, skip bit 3, both cleared by reset
// - luma results clipped to 0..255, negatives to zero
`timescale 1ns/1ps
`default_nettype none
module cmr_top
   import cmr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pix_in_valid,
   output logic pix_in_ready,
   input wire cmr_pix_t pix_in,
   output logic pix_out_valid,
   input wire logic pix_out_ready,
   output var cmr_pix_t pix_out
);
   // ************************************************************
   // declarations
   // ************************************************************
   localparam logic [3:0] SEL_CTRL = 4'h9;
   localparam logic [3:0] SEL_STATUS = 4'ha;
   localparam logic [3:0] SEL_NONE = 4'hf;

   cmr_coef_bank_t coef;
   cmr_ctrl_t ctrl;
   logic aw_held;
   logic w_held;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic next_aw_held;
   logic next_w_held;
   logic do_write;
   logic [3:0] wsel;
   logic [3:0] rsel;
   logic a_valid;
   logic next_a_valid;
   cmr_mat_in_t a_data;
   cmr_mat_out_t mat_res;
   cmr_pix_t fifo_wr_data;
   logic [23:0] fifo_rd_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [`CMR_FIFO_LVL_W-1:0] fifo_level;

   // ************************************************************
   // helpers
   // ************************************************************
   // word decode; unaligned or unknown addresses give SEL_NONE
   function automatic logic [3:0] reg_decode(input logic [7:0] a);
      logic [5:0] w;
      w = a[7:2];
      if (a[1:0] != 2'h0) return SEL_NONE;
      if (a == `CMR_OFF_CTRL) return SEL_CTRL;
      if (a == `CMR_OFF_STATUS) return SEL_STATUS;
      if (a >= `CMR_OFF_COEF1 && w < 6'(`CMR_NUM_COEF)) return w[3:0];
      return SEL_NONE;
   endfunction

   // ************************************************************
   // register bus: write channels
   // ************************************************************
   // address and data are held separately, so either may come first
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wsel = reg_decode(awaddr_q);

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      if (s_axi_awvalid && s_axi_awready) next_aw_held = 1'b1;
      if (s_axi_wvalid && s_axi_wready) next_w_held = 1'b1;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
      end
   end

   // capture of address and data, ready drops while one is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= !next_aw_held;
         s_axi_wready <= !next_w_held;
         if (s_axi_awvalid && s_axi_awready) awaddr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   // write response, unmapped addresses answer slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CMR_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wsel == SEL_NONE || wsel == SEL_STATUS)
            ? `CMR_RESP_SLVERR : `CMR_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // coefficient and control registers
   // ************************************************************
   // byte lane 0 carries bits 7:0, lane 1 the top nibble
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < `CMR_NUM_COEF; i++) begin
            coef[i] <= `CMR_COEF_RESET;
         end
      end else if (do_write && wsel < 4'(`CMR_NUM_COEF)) begin
         if (wstrb_q[0]) coef[wsel][7:0] <= wdata_q[7:0];
         if (wstrb_q[1]) coef[wsel][11:8] <= wdata_q[11:8];
      end
   end

   // all control bits clear at reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= '0;
      end else if (do_write && wsel == SEL_CTRL && wstrb_q[0]) begin
         ctrl.sel <= wdata_q[`CMR_CTRL_SEL_BIT];
         ctrl.dir <= wdata_q[`CMR_CTRL_DIR_BIT];
         ctrl.skip <= wdata_q[`CMR_CTRL_SKIP_BIT];
         ctrl.half <= wdata_q[`CMR_CTRL_HALF_BIT];
      end
   end

   // ************************************************************
   // register bus: read channel
   // ************************************************************
   assign rsel = reg_decode(s_axi_araddr);

   // one read at a time; arready returns once the data is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CMR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `CMR_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         if (rsel < 4'(`CMR_NUM_COEF)) begin
            s_axi_rdata[11:0] <= coef[rsel];
         end else if (rsel == SEL_CTRL) begin
            s_axi_rdata[`CMR_CTRL_SEL_BIT] <= ctrl.sel;
            s_axi_rdata[`CMR_CTRL_DIR_BIT] <= ctrl.dir;
            s_axi_rdata[`CMR_CTRL_SKIP_BIT] <= ctrl.skip;
            s_axi_rdata[`CMR_CTRL_HALF_BIT] <= ctrl.half;
         end else if (rsel == SEL_STATUS) begin
            s_axi_rdata[5:0] <= {pix_out_valid, a_valid, fifo_level};
         end else begin
            s_axi_rresp <= `CMR_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************************
   // pixel path: input conditioning stage
   // ************************************************************
   // one pixel is held here; it moves on when the FIFO takes it
   always_comb begin
      next_a_valid = a_valid;
      if (pix_in_valid && pix_in_ready) begin
         next_a_valid = 1'b1;
      end else if (fifo_in_ready) begin
         next_a_valid = 1'b0;
      end
   end

   // ready is registered, so the stage accepts every other cycle at most
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_valid <= 1'b0;
         pix_in_ready <= 1'b0;
      end else begin
         a_valid <= next_a_valid;
         pix_in_ready <= !next_a_valid;
      end
   end

   // direction low takes RGB, high takes luma and two chroma channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_data <= '0;
      end else if (pix_in_valid && pix_in_ready) begin
         if (!ctrl.dir) begin
            a_data.ch0 <= {2'b00, pix_in.ch0};
            a_data.ch1 <= {2'b00, pix_in.ch1};
            a_data.ch2 <= {2'b00, pix_in.ch2};
         end else begin
            a_data.ch0 <= prep_luma(pix_in.ch0, ctrl);
            a_data.ch1 <= prep_chroma(pix_in.ch1, ctrl);
            a_data.ch2 <= prep_chroma(pix_in.ch2, ctrl);
         end
      end
   end

   // ************************************************************
   // matrix and output ranging
   // ************************************************************
   cmr_matrix u_matrix (
      .mat_in(a_data),
      .coef(coef),
      .mat_out(mat_res)
   );

   // RGB results only need clipping; luma/chroma results are ranged
   always_comb begin
      if (ctrl.dir) begin
         fifo_wr_data.ch0 = cmr_clamp(16'(mat_res.ch0), `CMR_U8_MIN,
            `CMR_U8_MAX);
         fifo_wr_data.ch1 = cmr_clamp(16'(mat_res.ch1), `CMR_U8_MIN,
            `CMR_U8_MAX);
         fifo_wr_data.ch2 = cmr_clamp(16'(mat_res.ch2), `CMR_U8_MIN,
            `CMR_U8_MAX);
      end else begin
         fifo_wr_data.ch0 = post_luma(mat_res.ch0,
            ctrl);
         fifo_wr_data.ch1 = post_chroma(mat_res.ch1, ctrl);
         fifo_wr_data.ch2 = post_chroma(mat_res.ch2, ctrl);
      end
   end

   // ************************************************************
   // output buffering
   // ************************************************************
   cmr_fifo #(
      .WIDTH(24),
      .DEPTH(`CMR_FIFO_DEPTH),
      .LVL_W(`CMR_FIFO_LVL_W)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(a_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_wr_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_rd_data),
      .level(fifo_level)
   );

   // output register keeps the stream outputs off the FIFO read mux
   assign fifo_pop = fifo_out_valid && (!pix_out_valid || pix_out_ready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pix_out_valid <= 1'b0;
         pix_out <= '0;
      end else if (fifo_pop) begin
         pix_out_valid <= 1'b1;
         pix_out <= fifo_rd_data;
      end else if (pix_out_ready) begin
         pix_out_valid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [pkg/cmr_consts.svh]
// register offsets, control bit positions, limits, bus answers and buffer sizes
`ifndef CMR_CONSTS_SVH
`define CMR_CONSTS_SVH

// ************************************************************
// register map, byte addresses on the register bus
// ************************************************************
`define CMR_OFF_COEF1 8'h00
`define CMR_OFF_CTRL 8'h24
`define CMR_OFF_STATUS 8'h28
`define CMR_NUM_COEF 9

// control register bit positions
`define CMR_CTRL_SEL_BIT 1
`define CMR_CTRL_DIR_BIT 2
`define CMR_CTRL_SKIP_BIT 3
`define CMR_CTRL_HALF_BIT 4

// reset values
`define CMR_COEF_RESET 12'h000

// ************************************************************
// arithmetic limits, 16-bit signed working width; rounding term 24-bit
// ************************************************************
`define CMR_CHROMA_OFFSET 16'sh0080
`define CMR_WIDE_LO 16'sh0001
`define CMR_WIDE_HI 16'sh00fe
`define CMR_STUDIO_LO 16'sh0010
`define CMR_LUMA_HI 16'sh00eb
`define CMR_CHROMA_HI 16'sh00f0
`define CMR_U8_MIN 16'sh0000
`define CMR_U8_MAX 16'sh00ff
`define CMR_S8_MIN 16'shff80
`define CMR_S8_MAX 16'sh007f
`define CMR_ROUND_HALF 24'sh000100

// ************************************************************
// bus answers and buffering
// ************************************************************
`define CMR_RESP_OKAY 2'h0
`define CMR_RESP_SLVERR 2'h2
`define CMR_FIFO_DEPTH 8
`define CMR_FIFO_LVL_W 4

`endif

// [pkg/cmr_pkg.sv]
// types and shared helpers of the colour matrix and ranging block
`default_nettype none
package cmr_pkg;
`include "cmr_consts.svh"

   // ************************************************************
   // carriers
   // ************************************************************
   typedef logic signed [11:0] cmr_coef_t;
   typedef cmr_coef_t [8:0] cmr_coef_bank_t;

   // one pixel on the stream: three 8-bit channels
   typedef struct packed {
      logic [7:0] ch0;
      logic [7:0] ch1;
      logic [7:0] ch2;
   } cmr_pix_t;

   // matrix operands, 1.0 = 256
   typedef struct packed {
      logic signed [9:0] ch0;
      logic signed [9:0] ch1;
      logic signed [9:0] ch2;
   } cmr_mat_in_t;

   // matrix results, integer part after rounding
   typedef struct packed {
      logic signed [14:0] ch0;
      logic signed [14:0] ch1;
      logic signed [14:0] ch2;
   } cmr_mat_out_t;

   typedef struct packed {
      logic half;
      logic skip;
      logic dir;
      logic sel;
   } cmr_ctrl_t;

   // limit a value to [lo, hi] and return its low byte
   function automatic logic [7:0] cmr_clamp(input logic signed [15:0] v,
         input logic signed [15:0] lo, input logic signed [15:0] hi);
      logic signed [15:0] r;
      r = (v < lo) ? lo : ((v > hi) ? hi : v);
      return r[7:0];
   endfunction

   // ************************************************************
   // ranging and chroma scaling
   // ************************************************************
   function automatic logic signed [15:0] lim_lo(input cmr_ctrl_t k);
      return k.sel ? `CMR_WIDE_LO : `CMR_STUDIO_LO;
   endfunction

   function automatic logic signed [15:0] lim_luma(input cmr_ctrl_t k);
      return k.sel ? `CMR_WIDE_HI : `CMR_LUMA_HI;
   endfunction

   function automatic logic signed [15:0] lim_chroma(input cmr_ctrl_t k);
      return k.sel ? `CMR_WIDE_HI : `CMR_CHROMA_HI;
   endfunction

   // incoming luma: limited to the chosen range unless ranging is skipped
   function automatic logic signed [9:0] prep_luma(input logic [7:0] y,
         input cmr_ctrl_t k);
      logic [7:0] r;
      r = k.skip ? y
         : cmr_clamp({8'h00, y}, lim_lo(k), lim_luma(k));
      return {2'b00, r};
   endfunction

   // incoming chroma: offset binary or two's complement, then scaled
   function automatic logic signed [9:0] prep_chroma(input logic [7:0] c,
         input cmr_ctrl_t k);
      logic signed [15:0] v;
      v = {{8{c[7]}}, c};
      if (!k.skip) begin
         v = signed'({8'h00, cmr_clamp({8'h00, c}, lim_lo(k),
            lim_chroma(k))});
         v = v - `CMR_CHROMA_OFFSET;
      end
      // full scale +-1 needs one more bit inside than +-0.5
      if (!k.half) v = v <<< 1;
      return v[9:0];
   endfunction

   // outgoing luma: clip to a byte, then range it
   function automatic logic [7:0] post_luma(input logic signed [14:0] m,
         input cmr_ctrl_t k);
      logic [7:0] y;
      y = cmr_clamp(16'(m), `CMR_U8_MIN, `CMR_U8_MAX);
      if (k.skip) return y;
      return cmr_clamp({8'h00, y}, lim_lo(k), lim_luma(k));
   endfunction

   // outgoing chroma: rescale, clip to signed byte, optional offset
   function automatic logic [7:0] post_chroma(input logic signed [14:0] m,
         input cmr_ctrl_t k);
      logic signed [15:0] v;
      v = 16'(m);
      if (!k.half) v = (v + 16'sh0001) >>> 1;
      v = 16'(signed'(cmr_clamp(v, `CMR_S8_MIN, `CMR_S8_MAX)));
      if (k.skip) return v[7:0];
      v = v + `CMR_CHROMA_OFFSET;
      return cmr_clamp(v, lim_lo(k), lim_chroma(k));
   endfunction
endpackage
`default_nettype wire

// [core/cmr_fifo.sv]
// parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cmr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8,
   parameter int LVL_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [LVL_W-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic push;
   logic pop;

   // full and empty straight from the occupancy count
   assign in_ready = (level != LVL_W'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // wrap is explicit so a depth that is not a power of two still works
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   // storage, written at the write index
   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop) rd_ptr <= bump(rd_ptr);
         level <= LVL_W'(level + push - pop);
      end
   end
endmodule
`default_nettype wire

// [core/cmr_matrix.sv]
// 3x3 coefficient matrix: three sums of three products, rounded
`timescale 1ns/1ps
`default_nettype none
module cmr_matrix
   import cmr_pkg::*;
(
   input wire cmr_mat_in_t mat_in,
   input wire cmr_coef_bank_t coef,
   output var cmr_mat_out_t mat_out
);
   // ************************************************************
   // dot product
   // ************************************************************
   // coefficients are 3.9 fixed point, so 12'h200 is unity; 24 bits
   // hold the worst case of three full-scale products without overflow
   function automatic logic signed [14:0] dot3(input cmr_coef_t k0,
         input cmr_coef_t k1, input cmr_coef_t k2, input cmr_mat_in_t x);
      logic signed [23:0] acc;
      acc = 24'(k0 * x.ch0) + 24'(k1 * x.ch1) + 24'(k2 * x.ch2);
      acc = acc + `CMR_ROUND_HALF;
      return acc[23:9];
   endfunction

   // rows use coefficients 1-3, 4-6 and 7-9
   always_comb begin
      mat_out.ch0 = dot3(coef[0], coef[1], coef[2], mat_in);
      mat_out.ch1 = dot3(coef[3], coef[4], coef[5], mat_in);
      mat_out.ch2 = dot3(coef[6], coef[7], coef[8], mat_in);
   end
endmodule
`default_nettype wire

// [verif/cmr_checker.sv]
// concurrent checks on the colour matrix block's bus and stream ports
`timescale 1ns/1ps
`default_nettype none
module cmr_checker
   import cmr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic pix_in_valid,
   input wire logic pix_in_ready,
   input wire logic pix_out_valid,
   input wire logic pix_out_ready,
   input wire cmr_pix_t pix_out
);
   // ***************************************
   // one clock domain, reset masks everything
   // ***************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_reset_clear: assert property (
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
      && !pix_out_valid && !pix_in_ready)
      else $error("outputs not idle after reset");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid)
      else $error("write answer not on time");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not on time");
   // a second address must wait until the data has gone
   chk_read_refuse: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   chk_unmapped_zero: assert property (
      s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("refused read carries data");
   chk_pix_hold: assert property (
      pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out))
      else $error("pixel changed while stalled");
   chk_in_gap: assert property (
      pix_in_valid && pix_in_ready |=> !pix_in_ready)
      else $error("input taken on two cycles in a row");
   chk_pix_latency: assert property (
      pix_in_valid && pix_in_ready && !pix_out_valid
      |-> ##[1:3] pix_out_valid)
      else $error("pixel did not reach the output");

   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   cover property (pix_out_valid && !pix_out_ready);
   cover property (pix_in_valid && pix_in_ready);
endmodule
bind cmr_top cmr_checker i_chk (.*);
`default_nettype wire

// [verif/cmr_pix_model.sv]
// pixel source and sink that sit on the block's stream ports
`timescale 1ns/1ps
`default_nettype none
module cmr_pix_model
   import cmr_pkg::*;
(
   input wire logic aclk,
   output logic pix_in_valid,
   input wire logic pix_in_ready,
   output cmr_pix_t pix_in,
   input wire logic pix_out_valid,
   output logic pix_out_ready,
   input wire cmr_pix_t pix_out
);
   // ***************************************
   // source and sink
   // ***************************************
   logic stall;
   cmr_pix_t got[$];

   initial begin
      stall = 1'b0;
      pix_in_valid = 1'b0;
      pix_in = '0;
      pix_out_ready = 1'b0;
   end

   // hold the pixel until taken; the idle bus then shows the inverse
   task automatic send(input cmr_pix_t p);
      @(posedge aclk);
      pix_in_valid <= 1'b1;
      pix_in <= p;
      do @(posedge aclk); while (!pix_in_ready);
      pix_in_valid <= 1'b0;
      pix_in <= ~p;
   endtask

   // sink collects every handshaken pixel; stall models a slow consumer
   always @(posedge aclk) begin
      if (pix_out_valid && pix_out_ready) got.push_back(pix_out);
      pix_out_ready <= !stall;
   end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the colour matrix block
`timescale 1ns/1ps
`default_nettype none
`include "cmr_consts.svh"
module testbench
   import cmr_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = '0;
   logic [7:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic pix_in_valid, pix_in_ready, pix_out_valid, pix_out_ready;
   cmr_pix_t pix_in, pix_out;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [31:0] d;
   logic [1:0] r;

   cmr_top i_dut (.*);
   cmr_pix_model i_model (.*);

   always #10 aclk = ~aclk;

   // ***************************************
   // bus and stream tasks
   // ***************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // address and data leave separately, each when its ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // one pixel through with the block idle, so ctrl changes are safe
   task automatic px(input logic [7:0] c, input cmr_pix_t p,
         input cmr_pix_t e);
      wr(`CMR_OFF_CTRL, {24'h0, c});
      i_model.send(p);
      while (i_model.got.size() == 0) @(posedge aclk);
      chk(i_model.got.pop_front(), e);
   endtask

   task end_of_test;
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ***************************************
   // tests
   // ***************************************
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`CMR_OFF_CTRL);
      chk(d, 32'h0);
      chk(r, `CMR_RESP_OKAY);
      rd(`CMR_OFF_COEF1);
      chk(d, 32'h0);
      wr(`CMR_OFF_COEF1, 32'hffff_f200);
      rd(`CMR_OFF_COEF1);
      chk(d, 32'h0000_0200);
      wr(8'h10, 32'h0000_0e00);
      rd(8'h10);
      chk(d, 32'h0000_0e00);
      wr(8'h20, 32'h0000_0200);
      chk(r, `CMR_RESP_OKAY);
      wr(`CMR_OFF_CTRL, 32'h0a);
      rd(`CMR_OFF_CTRL);
      chk(d, 32'h0a);
      wr(`CMR_OFF_STATUS, 32'h0);
      chk(r, `CMR_RESP_SLVERR);
      rd(8'h30);
      chk(r, `CMR_RESP_SLVERR);
      chk(d, 32'h0);
      // rgb in, row 2 weight is minus one to reach the low limits
      px(8'h10, 24'hffff90, 24'heb10f0);
      px(8'h12, 24'h00ff90, 24'h0101fe);
      px(8'h10, 24'h7b050a, 24'h7b7b8a);
      px(8'h18, 24'hff0590, 24'hfffb7f);
      px(8'h08, 24'h000590, 24'h00fe48);
      wr(8'h10, 32'h0000_0200);
      // luma and chroma in, unity diagonal
      px(8'h16, 24'h00ff00, 24'h017e00);
      px(8'h14, 24'hfffff8, 24'heb7070);
      px(8'h04, 24'h109080, 24'h102000);
      // fill every stage with the sink stalled, then drain in order
      wr(`CMR_OFF_CTRL, 32'h18);
      i_model.stall <= 1'b1;
      for (int k = 0; k < 10; k++) i_model.send({k[7:0], 16'h0});
      repeat (4) @(posedge aclk);
      chk(pix_in_ready, 1'b0);
      rd(`CMR_OFF_STATUS);
      chk(d, 32'h38);
      i_model.stall <= 1'b0;
      while (i_model.got.size() < 10) @(posedge aclk);
      for (int k = 0; k < 10; k++) begin
         chk(i_model.got.pop_front(), {k[7:0], 16'h0});
      end
      end_of_test;
   end

   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      end_of_test;
   end
endmodule
`default_nettype wire
